// ===== core/nvb_ctrl.sv
// Byte EEPROM access controller: I/O registers, timed enable, programming sequencer
`timescale 1ns/1ps
module nvb_ctrl #(
    parameter int unsigned ATOMIC_TICKS = nvb_pkg::ATOMIC_TICKS,
    parameter int unsigned SPLIT_TICKS = nvb_pkg::SPLIT_TICKS
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [1:0] io_idx_i,
    input wire logic [7:0] io_wdata_i,
    output logic [7:0] io_rdata_o,
    input wire logic global_irq_en_i,
    output logic ready_irq_o,
    output logic cpu_stall_o
);
    //-------------------------------------------------------------------
    // State
    //-------------------------------------------------------------------
    typedef struct packed {
        logic [6:0] addr;
        logic [7:0] data;
        logic [1:0] mode;
        logic rie;
        logic mpe;
        logic [2:0] mpe_cnt;
        logic prog;
        logic [2:0] stall_cnt;
        nvb_pkg::nvb_state_t st;
        logic [11:0] tick_cnt;
        logic [7:0] rdata;
    } nvb_ctrl_state_t;

    nvb_ctrl_state_t s_reg;
    nvb_ctrl_state_t s_next;
    logic [7:0] mem [0:nvb_pkg::DEPTH-1];
    logic osc_tick;
    logic busy;
    logic mem_we;
    logic [7:0] mem_wval;
    logic wr_addr;
    logic wr_data;
    logic wr_ctrl;
    logic [7:0] ctrl_rd;
    logic [7:0] addr_rd;
    logic [11:0] op_ticks;

    nvb_osc_tick #(
        .DIV(nvb_pkg::OSC_DIV)
    ) u_osc (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .tick_o(osc_tick)
    );

    assign busy = (s_reg.st != nvb_pkg::ST_IDLE);
    assign wr_addr = io_wr_i && (io_idx_i == nvb_pkg::IDX_ADDR);
    assign wr_data = io_wr_i && (io_idx_i == nvb_pkg::IDX_DATA);
    assign wr_ctrl = io_wr_i && (io_idx_i == nvb_pkg::IDX_CTRL);
    assign op_ticks = (s_reg.mode == nvb_pkg::MODE_ATOMIC) ? 12'(ATOMIC_TICKS) :
        12'(SPLIT_TICKS);

    //-------------------------------------------------------------------
    // Next state
    //-------------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        mem_we = 1'b0;
        mem_wval = s_reg.data;
        if (s_reg.stall_cnt != 3'h0) begin
            s_next.stall_cnt = s_reg.stall_cnt - 3'h1;
        end
        if (s_reg.mpe) begin
            if (s_reg.mpe_cnt == 3'h1) begin
                s_next.mpe = 1'b0;
            end
            s_next.mpe_cnt = s_reg.mpe_cnt - 3'h1;
        end
        if (wr_addr && !busy) begin
            s_next.addr = io_wdata_i[6:0];
        end
        if (wr_data) begin
            s_next.data = io_wdata_i;
        end
        if (wr_ctrl) begin
            s_next.rie = io_wdata_i[nvb_pkg::BIT_RIE];
            if (!s_reg.prog) begin
                s_next.mode = io_wdata_i[nvb_pkg::BIT_MODE_HI:nvb_pkg::BIT_MODE_LO];
            end
            if (io_wdata_i[nvb_pkg::BIT_MPE] && !s_reg.mpe) begin
                s_next.mpe = 1'b1;
                s_next.mpe_cnt = nvb_pkg::MPE_CYCLES;
            end
            // Reserved mode 11 starts no programming; a set read strobe still starts a read
            if (io_wdata_i[nvb_pkg::BIT_PROG] && s_reg.mpe && !busy
                && s_reg.mode != 2'h3) begin
                s_next.prog = 1'b1;
                s_next.tick_cnt = op_ticks;
                s_next.st = (s_reg.mode == nvb_pkg::MODE_WRITE) ? nvb_pkg::ST_WRITE :
                    nvb_pkg::ST_ERASE;
                s_next.stall_cnt = nvb_pkg::PROG_STALL;
            end else if (io_wdata_i[nvb_pkg::BIT_READ] && !busy) begin
                // Read completes in the same write, so the strobe never reads back set
                s_next.data = mem[s_reg.addr];
                s_next.stall_cnt = nvb_pkg::READ_STALL;
            end
        end
        // Programming is timed in oscillator ticks, not CPU cycles
        if (busy && osc_tick) begin
            if (s_reg.tick_cnt <= 12'h001) begin
                mem_we = 1'b1;
                case (s_reg.mode)
                    nvb_pkg::MODE_ATOMIC: mem_wval = s_reg.data;
                    nvb_pkg::MODE_ERASE: mem_wval = nvb_pkg::ERASED_BYTE;
                    // No erase first: bits can only be cleared
                    nvb_pkg::MODE_WRITE: mem_wval = mem[s_reg.addr] & s_reg.data;
                    default: mem_we = 1'b0;
                endcase
                s_next.st = nvb_pkg::ST_IDLE;
                s_next.prog = 1'b0;
                s_next.tick_cnt = 12'h000;
            end else begin
                s_next.tick_cnt = s_reg.tick_cnt - 12'h001;
            end
        end
    end

    //-------------------------------------------------------------------
    // Registers
    //-------------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            s_reg.rie <= 1'b0;
            s_reg.mpe <= 1'b0;
            s_reg.mpe_cnt <= 3'h0;
            s_reg.stall_cnt <= 3'h0;
            s_reg.rdata <= 8'h00;
            // An operation in flight survives reset; its tick count holds until reset is released
            if (busy) begin
                s_reg.addr <= s_next.addr;
                s_reg.data <= s_next.data;
                s_reg.mode <= s_next.mode;
                s_reg.prog <= s_next.prog;
                s_reg.st <= s_next.st;
                s_reg.tick_cnt <= s_next.tick_cnt;
            end else begin
                s_reg.addr <= 7'h00;
                s_reg.data <= 8'h00;
                s_reg.mode <= nvb_pkg::MODE_RESET;
                s_reg.prog <= 1'b0;
                s_reg.st <= nvb_pkg::ST_IDLE;
                s_reg.tick_cnt <= 12'h000;
            end
        end else begin
            s_reg <= s_next;
            s_reg.rdata <= io_rdata_comb(io_idx_i);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (mem_we && (!rst_n_i ? busy : 1'b1)) begin
            mem[s_reg.addr] <= mem_wval;
        end
    end

    //-------------------------------------------------------------------
    // Read side
    //-------------------------------------------------------------------
    assign addr_rd = {1'b0, s_reg.addr};
    assign ctrl_rd = {2'b00, s_reg.mode, s_reg.rie, s_reg.mpe, s_reg.prog, 1'b0};

    function automatic logic [7:0] io_rdata_comb(input logic [1:0] idx);
        case (idx)
            nvb_pkg::IDX_ADDR: io_rdata_comb = addr_rd;
            nvb_pkg::IDX_DATA: io_rdata_comb = s_reg.data;
            nvb_pkg::IDX_CTRL: io_rdata_comb = ctrl_rd;
            default: io_rdata_comb = 8'h00;
        endcase
    endfunction

    // Read data is registered: sample one cycle after io_rd_i
    assign io_rdata_o = s_reg.rdata;
    assign ready_irq_o = s_reg.rie && global_irq_en_i && !s_reg.prog;
    assign cpu_stall_o = (s_reg.stall_cnt != 3'h0);

    logic unused_rd;
    assign unused_rd = io_rd_i;
endmodule // nvb_ctrl

// ===== core/nvb_osc_tick.sv
// Tick divider standing in for the calibrated internal oscillator
`timescale 1ns/1ps
module nvb_osc_tick #(
    parameter int unsigned DIV = 10
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    output logic tick_o
);
    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;

    always_comb begin
        if (cnt_reg == 16'(DIV - 1)) begin
            cnt_next = 16'h0000;
        end else begin
            cnt_next = cnt_reg + 16'h0001;
        end
    end

    // Restarted by reset so it never runs from an unknown count; an operation in
    // flight is stretched by the reset plus the partial tick count it discards, never cut short
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            cnt_reg <= 16'h0000;
        end else begin
            cnt_reg <= (cnt_reg > 16'(DIV - 1)) ? 16'h0000 : cnt_next;
        end
    end

    assign tick_o = (cnt_reg == 16'(DIV - 1));
endmodule // nvb_osc_tick

// ===== core/nvb_pkg.sv
// Package of register indices, bit fields and timing counts for the byte EEPROM controller
//-------------------------------------------------------------------
//-------------------------------------------------------------------
package nvb_pkg;
    localparam int unsigned DEPTH = 128;
    localparam int unsigned AW = 7;
    // Register indices on the I/O register port
    localparam logic [1:0] IDX_ADDR = 2'h0;
    localparam logic [1:0] IDX_DATA = 2'h1;
    localparam logic [1:0] IDX_CTRL = 2'h2;
    // Control field positions
    localparam int unsigned BIT_READ = 0;
    localparam int unsigned BIT_PROG = 1;
    localparam int unsigned BIT_MPE = 2;
    localparam int unsigned BIT_RIE = 3;
    localparam int unsigned BIT_MODE_LO = 4;
    localparam int unsigned BIT_MODE_HI = 5;
    // Programming modes
    localparam logic [1:0] MODE_ATOMIC = 2'h0;
    localparam logic [1:0] MODE_ERASE = 2'h1;
    localparam logic [1:0] MODE_WRITE = 2'h2;
    localparam logic [1:0] MODE_RESET = 2'h0;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    // Timing
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned OSC_HZ = 1_000_000;
    localparam int unsigned OSC_DIV = CLK_HZ / OSC_HZ;
    localparam int unsigned T_ATOMIC_US = 3400;
    localparam int unsigned T_SPLIT_US = 1800;
    localparam int unsigned ATOMIC_TICKS = T_ATOMIC_US * (OSC_HZ / 1_000_000);
    localparam int unsigned SPLIT_TICKS = T_SPLIT_US * (OSC_HZ / 1_000_000);
    localparam logic [2:0] MPE_CYCLES = 3'h4;
    localparam logic [2:0] PROG_STALL = 3'h2;
    localparam logic [2:0] READ_STALL = 3'h4;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ERASE = 2'b01,
        ST_WRITE = 2'b10
    } nvb_state_t;
endpackage

// ===== verification/nvb_cpu_model.sv
// CPU-side model issuing I/O register accesses
`timescale 1ns/1ps
module nvb_cpu_model (
    input wire logic mclk_i,
    input wire logic [7:0] io_rdata_i,
    input wire logic cpu_stall_i,
    output logic io_wr_o,
    output logic io_rd_o,
    output logic [1:0] io_idx_o,
    output logic [7:0] io_wdata_o
);
    initial begin
        io_wr_o = 1'b0;
        io_rd_o = 1'b0;
        io_idx_o = 2'h3;
        io_wdata_o = 8'h00;
    end
    // No access is launched while the core is held
    task automatic go(input logic w, input logic [1:0] idx, input logic [7:0] d);
        @(posedge mclk_i);
        while (cpu_stall_i === 1'b1) @(posedge mclk_i);
        io_wr_o <= w;
        io_rd_o <= ~w;
        io_idx_o <= idx;
        io_wdata_o <= d;
        @(posedge mclk_i);
        io_wr_o <= 1'b0;
        io_rd_o <= 1'b0;
        io_wdata_o <= ~d;
        // Hand back only once the registers updated by this edge have settled
        #1;
    endtask
    task automatic wr(input logic [1:0] idx, input logic [7:0] d);
        go(1'b1, idx, d);
    endtask
    task automatic rd(input logic [1:0] idx, output logic [7:0] d);
        go(1'b0, idx, 8'h00);
        d = io_rdata_i;
    endtask
endmodule // nvb_cpu_model

// ===== verification/nvb_ctrl_sva.sv
// Concurrent checks on the ports of the byte EEPROM controller
`timescale 1ns/1ps
module nvb_ctrl_sva (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic io_wr_i,
    input wire logic [1:0] io_idx_i,
    input wire logic [7:0] io_wdata_i,
    input wire logic [7:0] io_rdata_o,
    input wire logic global_irq_en_i,
    input wire logic ready_irq_o,
    input wire logic cpu_stall_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    a_ctrl_top_zero: assert property ($past(io_idx_i) == nvb_pkg::IDX_CTRL
        |-> io_rdata_o[7:6] == 2'h0) else $error("control top bits not zero");
    a_addr_top_zero: assert property ($past(io_idx_i) == nvb_pkg::IDX_ADDR
        |-> !io_rdata_o[7]) else $error("address bit 7 not zero");
    a_read_bit_clear: assert property ($past(io_idx_i) == nvb_pkg::IDX_CTRL
        |-> !io_rdata_o[nvb_pkg::BIT_READ]) else $error("read strobe reads one");
    a_irq_needs_gie: assert property (ready_irq_o |-> global_irq_en_i)
        else $error("ready interrupt without global enable");
    a_stall_min_two: assert property ($rose(cpu_stall_o) |-> cpu_stall_o[*2])
        else $error("stall shorter than two cycles");
    a_stall_max_four: assert property ($rose(cpu_stall_o) |-> ##[2:4] !cpu_stall_o)
        else $error("stall longer than four cycles");
    a_read_stall_four: assert property (io_wr_i && io_idx_i == nvb_pkg::IDX_CTRL
        && io_wdata_i[nvb_pkg::BIT_READ] && ready_irq_o |=> cpu_stall_o[*4] ##1 !cpu_stall_o)
        else $error("read stall not four cycles");
    a_prog_stall_two: assert property ($rose(cpu_stall_o) && $fell(ready_irq_o)
        && global_irq_en_i && $past(io_wdata_i[nvb_pkg::BIT_RIE])
        |-> ##1 cpu_stall_o ##1 !cpu_stall_o) else $error("program stall not two cycles");
endmodule // nvb_ctrl_sva
bind nvb_ctrl nvb_ctrl_sva u_sva (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .io_wr_i(io_wr_i),
    .io_idx_i(io_idx_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
    .global_irq_en_i(global_irq_en_i), .ready_irq_o(ready_irq_o), .cpu_stall_o(cpu_stall_o));

// ===== verification/nvb_ctrl_tb.sv
// Self-checking bench for the byte EEPROM controller
`timescale 1ns/1ps
module nvb_ctrl_tb;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic gie = 1'b0;
    logic wr, rd, irq, stall;
    logic [1:0] idx;
    logic [7:0] wd, rdat, v;
    int bad_count = 0;
    int checked = 0;
    initial forever #50 mclk_i = ~mclk_i;
    nvb_ctrl #(.ATOMIC_TICKS(5), .SPLIT_TICKS(3)) dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .io_wr_i(wr), .io_rd_i(rd), .io_idx_i(idx), .io_wdata_i(wd), .io_rdata_o(rdat),
        .global_irq_en_i(gie), .ready_irq_o(irq), .cpu_stall_o(stall));
    nvb_cpu_model cpu (.mclk_i(mclk_i), .io_rdata_i(rdat), .cpu_stall_i(stall),
        .io_wr_o(wr), .io_rd_o(rd), .io_idx_o(idx), .io_wdata_o(wd));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("Mismatches %0d of %0d comparisons", bad_count, checked);
        if (bad_count == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        cpu.rd(nvb_pkg::IDX_CTRL, v);
        while (v[nvb_pkg::BIT_PROG] !== 1'b0 && n < 300) begin
            cpu.rd(nvb_pkg::IDX_CTRL, v);
            n++;
        end
        chk({7'h0, v[nvb_pkg::BIT_PROG]}, 8'h00);
    endtask
    task automatic prog(input logic [1:0] mode, input logic [7:0] a, input logic [7:0] d);
        wait_ready();
        cpu.wr(nvb_pkg::IDX_ADDR, a);
        cpu.wr(nvb_pkg::IDX_DATA, d);
        cpu.wr(nvb_pkg::IDX_CTRL, {2'h0, mode, 4'hc});
        cpu.wr(nvb_pkg::IDX_CTRL, {2'h0, mode, 4'ha});
    endtask
    task automatic rdb(input logic [7:0] a, input logic [7:0] exp);
        wait_ready();
        cpu.wr(nvb_pkg::IDX_ADDR, a);
        cpu.wr(nvb_pkg::IDX_CTRL, 8'h09);
        cpu.rd(nvb_pkg::IDX_DATA, v);
        chk(v, exp);
    endtask
    //--------------------------------------------
    // Main sequence
    //--------------------------------------------
    initial begin
        repeat (10) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        cpu.rd(nvb_pkg::IDX_CTRL, v);
        chk(v, 8'h00);
        cpu.rd(2'h3, v);
        chk(v, 8'h00);
        cpu.wr(nvb_pkg::IDX_ADDR, 8'hff);
        cpu.rd(nvb_pkg::IDX_ADDR, v);
        chk(v, 8'h7f);
        cpu.wr(nvb_pkg::IDX_CTRL, 8'h08);
        chk({7'h0, irq}, 8'h00);
        @(posedge mclk_i);
        gie <= 1'b1;
        #1;
        chk({7'h0, irq}, 8'h01);
        prog(nvb_pkg::MODE_ATOMIC, 8'h05, 8'h3c);
        chk({7'h0, irq}, 8'h00);
        cpu.wr(nvb_pkg::IDX_ADDR, 8'h09);
        cpu.wr(nvb_pkg::IDX_CTRL, 8'h3b);
        cpu.rd(nvb_pkg::IDX_CTRL, v);
        chk(v, 8'h0a);
        cpu.rd(nvb_pkg::IDX_ADDR, v);
        chk(v, 8'h05);
        rdb(8'h05, 8'h3c);
        cpu.wr(nvb_pkg::IDX_CTRL, 8'h0a);
        cpu.rd(nvb_pkg::IDX_CTRL, v);
        chk(v, 8'h08);
        cpu.wr(nvb_pkg::IDX_CTRL, 8'h0c);
        repeat (4) @(posedge mclk_i);
        cpu.rd(nvb_pkg::IDX_CTRL, v);
        chk(v, 8'h08);
        cpu.wr(nvb_pkg::IDX_CTRL, 8'h0a);
        cpu.rd(nvb_pkg::IDX_CTRL, v);
        chk(v, 8'h08);
        prog(nvb_pkg::MODE_ERASE, 8'h05, 8'h00);
        rdb(8'h05, 8'hff);
        prog(nvb_pkg::MODE_WRITE, 8'h05, 8'h5a);
        rdb(8'h05, 8'h5a);
        prog(2'h3, 8'h05, 8'h00);
        cpu.rd(nvb_pkg::IDX_CTRL, v);
        // Enable is still inside its four-cycle window when this read is taken
        chk(v, 8'h3c);
        rdb(8'h05, 8'h5a);
        prog(nvb_pkg::MODE_ERASE, 8'h07, 8'h00);
        // Reset in mid-erase: the cell timer must carry on
        @(posedge mclk_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        cpu.rd(nvb_pkg::IDX_CTRL, v);
        chk(v, 8'h12);
        rdb(8'h07, 8'hff);
        wrap_up();
    end
    initial begin
        repeat (20000) @(posedge mclk_i);
        bad_count++;
        wrap_up();
    end
endmodule // nvb_ctrl_tb
